/* sli_pkg.sv */
`default_nettype none
package sli_pkg;
   localparam int unsigned SLI_CLK_MHZ       = 200;
   // Shortest spacing of acquisition toggles, in milliseconds.
   localparam int unsigned SLI_ACQ_MIN_MS    = 100;
   localparam int unsigned SLI_ACQ_MIN_CYC   = SLI_ACQ_MIN_MS * SLI_CLK_MHZ
                                               * 1000;
   // Half periods of the three blink rates, in milliseconds.
   localparam int unsigned SLI_RED_HALF_MS   = 250;
   localparam int unsigned SLI_SLOW_HALF_MS  = 500;
   localparam int unsigned SLI_FAST_HALF_MS  = 60;
   localparam int unsigned SLI_RED_HALF_CYC  = SLI_RED_HALF_MS * SLI_CLK_MHZ
                                               * 1000;
   localparam int unsigned SLI_SLOW_HALF_CYC = SLI_SLOW_HALF_MS * SLI_CLK_MHZ
                                               * 1000;
   localparam int unsigned SLI_FAST_HALF_CYC = SLI_FAST_HALF_MS * SLI_CLK_MHZ
                                               * 1000;

   localparam int unsigned SLI_CNT_W = 32;

   localparam logic [7:0] SLI_REG_CTRL     = 8'h00;
   localparam logic [7:0] SLI_REG_RED      = 8'h04;
   localparam logic [7:0] SLI_REG_SLOW     = 8'h08;
   localparam logic [7:0] SLI_REG_FAST     = 8'h0c;
   localparam logic [7:0] SLI_REG_STATUS   = 8'h10;
   localparam logic [7:0] SLI_REG_IRQ_STAT = 8'h14;
   localparam logic [7:0] SLI_REG_IRQ_MASK = 8'h18;

   localparam int unsigned SLI_CTRL_EN_BIT   = 0;
   localparam logic        SLI_CTRL_EN_RST   = 1'h1;
   localparam int unsigned SLI_IRQ_W         = 2;
   localparam int unsigned SLI_IRQ_CHG_BIT   = 0;
   localparam int unsigned SLI_IRQ_FATAL_BIT = 1;
   localparam int unsigned SLI_STS_RED_BIT   = 4;
   localparam int unsigned SLI_STS_GRN_BIT   = 5;
   localparam int unsigned SLI_STS_BLU_BIT   = 6;

   typedef enum logic [2:0] {
      SLI_ST_PWRUP,
      SLI_ST_FATAL,
      SLI_ST_INIT,
      SLI_ST_ACQ,
      SLI_ST_XFER,
      SLI_ST_APP,
      SLI_ST_ADDR,
      SLI_ST_SEARCH
   } sli_state_t;

   function automatic logic [31:0] sli_apply_sel(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction
endpackage
`default_nettype wire

/* sli_blink_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sli_blink_if;
   logic [31:0] half;
   logic        restart;
   logic        phase;
   modport ctl (output half, output restart, input phase);
   modport gen (input half, input restart, output phase);
endinterface // sli_blink_if
`default_nettype wire

/* sli_blinker.sv */
`timescale 1ns/10ps
`default_nettype none
module sli_blinker
   import sli_pkg::*;
(
   input  wire logic clk,
   input  wire logic arst_n,
   sli_blink_if.gen  bl
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        phase_q;
   logic        wrap;

   // A zero half period behaves as one cycle so the lamp never freezes.
   assign wrap  = (cnt_q + 32'h1 >= bl.half);
   assign cnt_d = (bl.restart || wrap) ? 32'h0 : cnt_q + 32'h1;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q   <= 32'h0;
         phase_q <= 1'b1;
      end
      else
      begin
         cnt_q   <= cnt_d;
         phase_q <= bl.restart ? 1'b1 : (wrap ? ~phase_q : phase_q);
      end
   end

   assign bl.phase = phase_q;

   chk_phase_on_wrap: assert property (
      @(posedge clk) disable iff (!arst_n)
      ($changed(phase_q) && !$past(bl.restart))
      |-> ($past(cnt_q) + 32'h1 >= $past(bl.half)))
      else $error("Blink phase changed before its half period ended.");
endmodule // sli_blinker
`default_nettype wire

/* sli_lamp.sv */
`timescale 1ns/10ps
`default_nettype none
module sli_lamp
   import sli_pkg::*;
#(
   parameter int unsigned ACQ_MIN_CYC   = SLI_ACQ_MIN_CYC,
   parameter int unsigned RED_HALF_RST  = SLI_RED_HALF_CYC,
   parameter int unsigned SLOW_HALF_RST = SLI_SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF_RST = SLI_FAST_HALF_CYC
)
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        init_busy,
   input  wire logic        fatal_err,
   input  wire logic        cable_up,
   input  wire logic        file_xfer,
   input  wire logic        addr_valid,
   input  wire logic        app_link,
   input  wire logic        acq_busy,
   input  wire logic        frame_done,
   output logic             lamp_red,
   output logic             lamp_green,
   output logic             lamp_blue,
   output logic             irq
);
   localparam logic [31:0] ACQ_MIN = 32'(ACQ_MIN_CYC);

   sli_blink_if red_bl ();
   sli_blink_if slow_bl ();
   sli_blink_if fast_bl ();

   // Conditions come from logic on this clock, so one register stage.
   logic [7:0]   cnd_q;
   logic         c_init, c_fatal, c_cable, c_xfer;
   logic         c_addr, c_app, c_acq, c_frame;
   logic         started_q;
   sli_state_t   state_q;
   sli_state_t   state_d;
   logic         st_chg;
   logic [31:0]  acq_cnt_q;
   logic         acq_full;
   logic         acq_tog_q;
   logic         acq_tog_d;
   logic         red_d, grn_d, blu_d;
   logic         red_q, grn_q, blu_q;
   logic         en_q;
   logic [31:0]  red_half_q, slow_half_q, fast_half_q;
   logic [SLI_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_set;
   logic         fatal_prev_q;
   logic         ack_q;
   logic [31:0]  rdat_q;
   logic         req, wr, rd;
   logic [7:0]   adr;
   logic         hit_ctrl, hit_red, hit_slow, hit_fast;
   logic         hit_sts, hit_istat, hit_imask;
   logic [31:0]  ctrl_rd, sts_rd, rd_mux;
   logic [31:0]  ctrl_new, istat_clr, imask_new;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cnd_q <= 8'h0;
      else
         cnd_q <= {frame_done, acq_busy, app_link, addr_valid,
                   file_xfer, cable_up, fatal_err, init_busy};
   end

   assign {c_frame, c_acq, c_app, c_addr,
           c_xfer, c_cable, c_fatal, c_init} = cnd_q;

   // Power-up red holds until the first sign of initialization.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         started_q <= 1'b0;
      else if (c_init)
         started_q <= 1'b1;
   end

   // Fixed priority chain, strongest first.
   assign state_d = c_fatal            ? SLI_ST_FATAL  :
                    !started_q         ? SLI_ST_PWRUP  :
                    c_init             ? SLI_ST_INIT   :
                    c_acq              ? SLI_ST_ACQ    :
                    c_xfer             ? SLI_ST_XFER   :
                    c_app              ? SLI_ST_APP    :
                    (c_addr && c_cable) ? SLI_ST_ADDR  :
                                         SLI_ST_SEARCH;
   assign st_chg = (state_d != state_q);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= SLI_ST_PWRUP;
      else
         state_q <= state_d;
   end

   // Blink generators restart on every pattern change for a clean start.
   assign red_bl.half     = red_half_q;
   assign red_bl.restart  = st_chg;
   assign slow_bl.half    = slow_half_q;
   assign slow_bl.restart = st_chg;
   assign fast_bl.half    = fast_half_q;
   assign fast_bl.restart = st_chg;

   sli_blinker u_red  (.clk(clk), .arst_n(arst_n), .bl(red_bl));
   sli_blinker u_slow (.clk(clk), .arst_n(arst_n), .bl(slow_bl));
   sli_blinker u_fast (.clk(clk), .arst_n(arst_n), .bl(fast_bl));

   // Frames that arrive faster than the minimum spacing are dropped.
   assign acq_full  = (acq_cnt_q >= ACQ_MIN);
   assign acq_tog_d = (c_frame && acq_full) ? ~acq_tog_q : acq_tog_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         acq_cnt_q <= 32'h0;
         acq_tog_q <= 1'b1;
      end
      else
      begin
         acq_tog_q <= acq_tog_d;
         if (c_frame && acq_full)
            acq_cnt_q <= 32'h0;
         else if (!acq_full)
            acq_cnt_q <= acq_cnt_q + 32'h1;
      end
   end

   always_comb
   begin
      red_d = 1'b0;
      grn_d = 1'b0;
      blu_d = 1'b0;
      case (state_q)
         SLI_ST_PWRUP:  red_d = 1'b1;
         SLI_ST_FATAL:
         begin
            red_d = 1'b1;
            blu_d = red_bl.phase;
         end
         SLI_ST_INIT:   red_d = red_bl.phase;
         SLI_ST_ACQ:    grn_d = acq_tog_q;
         SLI_ST_XFER:   blu_d = fast_bl.phase;
         SLI_ST_APP:    grn_d = 1'b1;
         SLI_ST_ADDR:   blu_d = 1'b1;
         SLI_ST_SEARCH: blu_d = slow_bl.phase;
         default:       red_d = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         red_q <= 1'b0;
         grn_q <= 1'b0;
         blu_q <= 1'b0;
      end
      else
      begin
         red_q <= red_d & en_q;
         grn_q <= grn_d & en_q;
         blu_q <= blu_d & en_q;
      end
   end

   assign lamp_red   = red_q;
   assign lamp_green = grn_q;
   assign lamp_blue  = blu_q;

   // Wishbone slave: one wait state, ack drops in the following cycle.
   assign req       = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr        = req && wb_we_i;
   assign rd        = req && !wb_we_i;
   assign adr       = {wb_adr_i[7:2], 2'b00};
   assign hit_ctrl  = (adr == SLI_REG_CTRL);
   assign hit_red   = (adr == SLI_REG_RED);
   assign hit_slow  = (adr == SLI_REG_SLOW);
   assign hit_fast  = (adr == SLI_REG_FAST);
   assign hit_sts   = (adr == SLI_REG_STATUS);
   assign hit_istat = (adr == SLI_REG_IRQ_STAT);
   assign hit_imask = (adr == SLI_REG_IRQ_MASK);

   assign ctrl_rd = {31'h0, en_q};
   assign sts_rd  = {25'h0, blu_q, grn_q, red_q, 1'b0, state_q};
   assign rd_mux  = hit_ctrl  ? ctrl_rd :
                    hit_red   ? red_half_q :
                    hit_slow  ? slow_half_q :
                    hit_fast  ? fast_half_q :
                    hit_sts   ? sts_rd :
                    hit_istat ? {30'h0, irq_stat_q} :
                    hit_imask ? {30'h0, irq_mask_q} : 32'h0;

   assign ctrl_new  = sli_apply_sel(ctrl_rd, wb_dat_i, wb_sel_i);
   assign istat_clr = sli_apply_sel(32'h0, wb_dat_i, wb_sel_i);
   assign imask_new = sli_apply_sel({30'h0, irq_mask_q}, wb_dat_i, wb_sel_i);

   // Events: any pattern change, and a fresh fatal error.
   assign irq_set = {c_fatal && !fatal_prev_q, st_chg};
   // A set in the same cycle as its write-one-to-clear wins.
   assign irq_stat_d = (irq_stat_q
                        & ~((wr && hit_istat) ? istat_clr[SLI_IRQ_W-1:0]
                                              : {SLI_IRQ_W{1'b0}}))
                       | irq_set;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_q        <= 1'b0;
         rdat_q       <= 32'h0;
         en_q         <= SLI_CTRL_EN_RST;
         red_half_q   <= 32'(RED_HALF_RST);
         slow_half_q  <= 32'(SLOW_HALF_RST);
         fast_half_q  <= 32'(FAST_HALF_RST);
         irq_stat_q   <= {SLI_IRQ_W{1'b0}};
         irq_mask_q   <= {SLI_IRQ_W{1'b0}};
         fatal_prev_q <= 1'b0;
      end
      else
      begin
         ack_q        <= req;
         rdat_q       <= rd ? rd_mux : 32'h0;
         irq_stat_q   <= irq_stat_d;
         fatal_prev_q <= c_fatal;
         if (wr && hit_ctrl)
            en_q <= ctrl_new[SLI_CTRL_EN_BIT];
         if (wr && hit_red)
            red_half_q <= sli_apply_sel(red_half_q, wb_dat_i, wb_sel_i);
         if (wr && hit_slow)
            slow_half_q <= sli_apply_sel(slow_half_q, wb_dat_i, wb_sel_i);
         if (wr && hit_fast)
            fast_half_q <= sli_apply_sel(fast_half_q, wb_dat_i, wb_sel_i);
         if (wr && hit_imask)
            irq_mask_q <= imask_new[SLI_IRQ_W-1:0];
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign irq      = |(irq_stat_q & irq_mask_q);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_acq_over_addr: assert property (
      (c_acq && c_addr && c_cable && started_q && !c_fatal && !c_init)
      |=> state_q == SLI_ST_ACQ)
      else $error("Acquisition did not outrank address held.");
   chk_pwrup_red: assert property (
      (state_q == SLI_ST_PWRUP && en_q) |=> (red_q && !grn_q && !blu_q))
      else $error("Power-up state not steady red.");
   chk_red_leaves: assert property (
      (started_q && !c_fatal) |=> state_q != SLI_ST_PWRUP)
      else $error("Steady red kept without a fatal error.");
   chk_init_blink: assert property (
      (state_q == SLI_ST_INIT && en_q) |=>
      (red_q == $past(red_bl.phase) && !grn_q && !blu_q))
      else $error("Initialization not shown as blinking red.");
   chk_fatal_pattern: assert property (
      (state_q == SLI_ST_FATAL && en_q) |=>
      (red_q && blu_q == $past(red_bl.phase) && !grn_q))
      else $error("Fatal error pattern wrong.");
   chk_slow_blue: assert property (
      (state_q == SLI_ST_SEARCH && en_q) |=>
      (blu_q == $past(slow_bl.phase) && !red_q && !grn_q))
      else $error("Detached cable not shown as slow blue.");
   chk_fast_blue: assert property (
      (state_q == SLI_ST_XFER && en_q) |=>
      (blu_q == $past(fast_bl.phase) && !red_q && !grn_q))
      else $error("File transfer not shown as fast blue.");
   chk_steady_blue: assert property (
      (state_q == SLI_ST_ADDR && en_q) ##1 (state_q == SLI_ST_ADDR)
      |-> (blu_q && !red_q && !grn_q))
      else $error("Address held not shown as steady blue.");
   chk_steady_green: assert property (
      (state_q == SLI_ST_APP && en_q) |=> (grn_q && !red_q && !blu_q))
      else $error("Application link not shown as steady green.");
   chk_acq_spacing: assert property (
      $changed(acq_tog_q) |-> ($past(acq_cnt_q) >= ACQ_MIN))
      else $error("Acquisition toggle came too soon.");
   chk_fatal_follows: assert property (
      $rose(fatal_err) |-> ##2 state_q == SLI_ST_FATAL)
      else $error("Fatal error not shown two cycles later.");
   chk_irq_sticky: assert property (
      (irq_stat_q[SLI_IRQ_CHG_BIT] && !(wr && hit_istat))
      |=> irq_stat_q[SLI_IRQ_CHG_BIT])
      else $error("Interrupt status bit lost without a clear.");

   cov_acq_toggle: cover property (state_q == SLI_ST_ACQ
                                   && $changed(acq_tog_q));
   cov_fatal:      cover property (state_q == SLI_ST_FATAL ##1 blu_q);
   cov_xfer:       cover property (state_q == SLI_ST_XFER ##1 blu_q);
   cov_irq:        cover property ($rose(irq));
endmodule // sli_lamp
`default_nettype wire

/* sli_lamp_test.sv */
`timescale 1ns/10ps
`default_nettype none
module sli_lamp_test
   import sli_pkg::*;
();
   logic        clk;
   logic        arst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic        ack;
   logic        irq;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [3:0]  bsel = 4'hf;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic [31:0] v;
   logic [6:0]  cnd;
   logic        frame;
   logic [2:0]  lamp;
   int          num_errors = 0;
   int          n_checks = 0;
   int          h;
   int          last;
   int          mn;
   int          cnt;
   logic        g;
   logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c};
   logic [31:0] re [6] = '{32'h1, 32'h4, 32'h9, 32'h2, 32'h0, 32'h0};

   // Condition order: acq, app, addr, cable, xfer, fatal, init.
   sli_lamp #(.ACQ_MIN_CYC(50), .RED_HALF_RST(4), .SLOW_HALF_RST(9),
              .FAST_HALF_RST(2)) DUT (
      .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .init_busy(cnd[0]),
      .fatal_err(cnd[1]), .file_xfer(cnd[2]), .cable_up(cnd[3]),
      .addr_valid(cnd[4]), .app_link(cnd[5]), .acq_busy(cnd[6]),
      .frame_done(frame), .lamp_red(lamp[0]), .lamp_green(lamp[1]),
      .lamp_blue(lamp[2]), .irq(irq));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Values are read just after the edge, so they are what the edge saw.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= bsel;
      wdat <= d;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (ack === 1'b1)
            break;
      end
      // A hung bus ends the run here, so nothing may follow the report.
      if (i == 50)
      begin
         num_errors++;
         conclude();
      end
      else
      begin
         v = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
         we  <= 1'b0;
      end
   endtask

   task automatic set(input logic [6:0] c);
      @(posedge clk);
      cnd <= c;
      repeat (10) @(posedge clk);
   endtask

   task automatic state(input sli_state_t e);
      bus(1'b0, SLI_REG_STATUS, 32'h0);
      check("state", {29'h0, v[2:0]}, {29'h0, e});
   endtask

   // Counts edges between two successive changes of one lamp colour.
   task automatic blink(input int idx);
      logic p;
      int   i;
      @(posedge clk);
      p = lamp[idx];
      for (i = 0; i < 100 && lamp[idx] === p; i++)
         @(posedge clk);
      p = lamp[idx];
      for (h = 0; h < 100 && lamp[idx] === p; h++)
         @(posedge clk);
   endtask

   task automatic steady(input int idx, input logic e);
      logic s;
      s = e;
      repeat (30)
      begin
         @(posedge clk);
         if (lamp[idx] !== e)
            s = lamp[idx];
      end
      check("steady lamp", {31'h0, s}, {31'h0, e});
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      conclude();
   end

   initial
   begin
      arst_n = 1'b0;
      {cyc, stb, we, frame} = 4'h0;
      adr  = 8'h00;
      sel  = 4'h0;
      wdat = 32'h0;
      cnd  = 7'h00;
      repeat (3) @(posedge clk);
      check("reset lamps", {29'h0, lamp}, 32'h0);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      steady(0, 1'b1);
      check("pwrup lamps", {29'h0, lamp}, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b0, ra[i], 32'h0);
         check("reset reg", v, re[i]);
      end
      bus(1'b1, 8'h1c, 32'hffff_ffff);
      bus(1'b0, 8'h1c, 32'h0);
      check("unmapped", v, 32'h0);
      // Address held before init must not end the power-up red.
      set(7'h18);
      steady(0, 1'b1);
      state(SLI_ST_PWRUP);
      set(7'h19);
      state(SLI_ST_INIT);
      blink(0);
      check("init red half", h, 32'd4);
      steady(2, 1'b0);
      bus(1'b1, SLI_REG_RED, 32'h6);
      blink(0);
      check("red prog half", h, 32'd6);
      // Only the low byte is enabled, so the upper ones must stay zero.
      bsel = 4'h1;
      bus(1'b1, SLI_REG_RED, 32'hffff_ff04);
      bsel = 4'hf;
      bus(1'b0, SLI_REG_RED, 32'h0);
      check("sel write", v, 32'h4);
      set(7'h1b);
      state(SLI_ST_FATAL);
      steady(0, 1'b1);
      blink(2);
      check("fatal blue", h, 32'd4);
      bus(1'b0, SLI_REG_IRQ_STAT, 32'h0);
      check("fatal event", {31'h0, v[1]}, 32'h1);
      check("change event", {31'h0, v[0]}, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      bus(1'b1, SLI_REG_IRQ_MASK, 32'h2);
      check("irq on", {31'h0, irq}, 32'h1);
      bus(1'b1, SLI_REG_IRQ_STAT, 32'h2);
      check("irq cleared", {31'h0, irq}, 32'h0);
      set(7'h10);
      state(SLI_ST_SEARCH);
      blink(2);
      check("slow blue", h, 32'd9);
      steady(0, 1'b0);
      set(7'h14);
      state(SLI_ST_XFER);
      blink(2);
      check("fast blue", h, 32'd2);
      set(7'h18);
      state(SLI_ST_ADDR);
      check("status lamps", {29'h0, v[6:4]}, 32'h4);
      steady(2, 1'b1);
      set(7'h38);
      state(SLI_ST_APP);
      steady(1, 1'b1);
      steady(2, 1'b0);
      // Clearing the lamp enable must blank even a steady colour.
      bus(1'b1, SLI_REG_CTRL, 32'h0);
      steady(1, 1'b0);
      bus(1'b1, SLI_REG_CTRL, 32'h1);
      steady(1, 1'b1);
      set(7'h78);
      state(SLI_ST_ACQ);
      // Frames every 10 cycles must still toggle no closer than 50.
      last = -1;
      mn   = 1000;
      cnt  = 0;
      g    = lamp[1];
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk);
         frame <= (i % 10 == 0);
         if (lamp[1] !== g)
         begin
            g = lamp[1];
            if (last >= 0 && i - last < mn)
               mn = i - last;
            last = i;
            cnt++;
         end
      end
      frame <= 1'b0;
      check("acq gap", {31'h0, mn >= 50 && mn <= 60}, 32'h1);
      check("acq toggles", {31'h0, cnt >= 5}, 32'h1);
      conclude();
   end
endmodule // sli_lamp_test
`default_nettype wire
